// file: common/crlc_consts.vh
// Constants for the reference ladder control block
`ifndef CRLC_CONSTS_VH
`define CRLC_CONSTS_VH

`define CRLC_ADDR_W          4
`define CRLC_DATA_W          8
`define CRLC_CTRL_OFFSET     4'h0
`define CRLC_STAT_OFFSET     4'h1
`define CRLC_CTRL_RESET      8'h00
`define CRLC_POWER_BIT       7
`define CRLC_PINOE_BIT       6
`define CRLC_RANGE_BIT       5
`define CRLC_SOURCE_BIT      4
`define CRLC_TAP_HI          3
`define CRLC_TAP_LO          0
`define CRLC_TAP_W           4
`define CRLC_TAP_COUNT       16
`define CRLC_PIN_DIR_BIT     5
`define CRLC_PORT_W          8
`define CRLC_LOW_STEP_DIV    8'h18
`define CRLC_HIGH_STEP_DIV   8'h20
`define CRLC_HIGH_BASE_TAPS  8'h08
`define CRLC_UNMAPPED_DATA   8'h00
`define CRLC_WORD_ZERO       8'h00
`define CRLC_ONEHOT_ZERO     16'h0000
`define CRLC_ONE_BIT         1'b1
`define CRLC_ZERO_BIT        1'b0

`endif

// file: rtl/crlc_ladder_ctrl.v
// Register and control logic for the comparator reference ladder
//
// How it works
// - Sixteen ladder taps give sixteen levels in each of two ranges.
// - Control bit 7 powers the reference on when set, down when clear.
// - Control bit 6 routes the reference onto the shared analog pin.
// - Bit 5 set picks low range, step 1/24; clear picks high, 1/4 base, 1/32.
// - Bit 4 set takes supply from reference pins, clear from analog rails.
// - Bits 3 to 0 hold the unsigned tap code, zero to fifteen.
// - Any device reset clears the whole control register.
// - Waking from sleep leaves the control register unchanged.
// - Pin gets reference only when output enable and direction-input bit set.
// - Reference control is independent of comparator mode settings.
`timescale 1ns/10ps
`include "crlc_consts.vh"

module crlc_ladder_ctrl #(
  parameter ADDR_W = `CRLC_ADDR_W,
  parameter DATA_W = `CRLC_DATA_W,
  parameter TAPS   = `CRLC_TAP_COUNT,
  parameter TAP_W  = `CRLC_TAP_W,
  parameter PORT_W = `CRLC_PORT_W
) (
  input  wire              clk,                      // System clock, 50 MHz
  input  wire              rst,                      // Async reset, active high
  input  wire [ADDR_W-1:0] reg_addr,                 // Register address
  input  wire [DATA_W-1:0] reg_wdata,                // Write data
  input  wire              reg_wr,                   // Write strobe
  input  wire              reg_rd,                   // Read strobe
  output reg  [DATA_W-1:0] reg_rdata,                // Read data, cycle after strobe
  input  wire [PORT_W-1:0] port_f_direction,         // Port F direction, 1 = input
  input  wire              sleep_active,             // Device asleep
  output reg               ladder_power_enable,      // Ladder powered
  output reg               ladder_pin_output_enable, // Pin switch closed
  output reg               ladder_range_select,      // 1 = low range
  output reg               ladder_source_select,     // 1 = external reference pins
  output reg  [TAP_W-1:0]  ladder_tap_code,          // Tap code to ladder
  output reg  [TAPS-1:0]   ladder_tap_switch,        // One-hot tap switches
  output reg  [7:0]        ladder_step_divisor,      // Span divisor of the range
  output reg  [7:0]        ladder_base_taps          // Base offset in 1/32 steps
);

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  reg  [DATA_W-1:0] reference_ladder_control_reg;
  reg  [DATA_W-1:0] reference_ladder_control_next;
  wire              ctrl_hit;
  wire              stat_hit;

  assign ctrl_hit = (reg_addr == `CRLC_CTRL_OFFSET);
  assign stat_hit = (reg_addr == `CRLC_STAT_OFFSET);

  // Only a write changes the register; comparator settings never feed it
  always @* begin
    reference_ladder_control_next = reference_ladder_control_reg;
    if (reg_wr && ctrl_hit) begin
      reference_ladder_control_next = reg_wdata;
    end
  end

  // Reset clears all bits; sleep and wake have no path here
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reference_ladder_control_reg <= `CRLC_CTRL_RESET;
    end else begin
      reference_ladder_control_reg <= reference_ladder_control_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ladder drive, computed from the next value so outputs move with the write

  wire              nxt_power;
  wire              nxt_pinoe;
  wire              nxt_range;
  wire              nxt_source;
  wire [TAP_W-1:0]  nxt_tap;
  wire [TAPS-1:0]   nxt_onehot;
  wire              pin_is_input;

  assign nxt_power  = reference_ladder_control_next[`CRLC_POWER_BIT];
  assign nxt_pinoe  = reference_ladder_control_next[`CRLC_PINOE_BIT];
  assign nxt_range  = reference_ladder_control_next[`CRLC_RANGE_BIT];
  assign nxt_source = reference_ladder_control_next[`CRLC_SOURCE_BIT];
  assign nxt_tap    = reference_ladder_control_next[`CRLC_TAP_HI:`CRLC_TAP_LO];
  assign pin_is_input = port_f_direction[`CRLC_PIN_DIR_BIT];

  // Tap switches open while the ladder is powered down
  crlc_tap_decode #(
    .TAPS  (TAPS),
    .TAP_W (TAP_W)
  ) u_tap_decode (
    .tap_code   (nxt_tap),
    .enable     (nxt_power),
    .tap_onehot (nxt_onehot)
  );

  // Registered outputs so the analog side sees glitch-free levels
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ladder_power_enable      <= `CRLC_ZERO_BIT;
      ladder_pin_output_enable <= `CRLC_ZERO_BIT;
      ladder_range_select      <= `CRLC_ZERO_BIT;
      ladder_source_select     <= `CRLC_ZERO_BIT;
      ladder_tap_code          <= {TAP_W{`CRLC_ZERO_BIT}};
      ladder_tap_switch        <= {TAPS{`CRLC_ZERO_BIT}};
      ladder_step_divisor      <= `CRLC_HIGH_STEP_DIV;
      ladder_base_taps         <= `CRLC_HIGH_BASE_TAPS;
    end else begin
      ladder_power_enable      <= nxt_power;
      // Pin switch needs the pin set as input, else a driven pin would fight
      ladder_pin_output_enable <= nxt_pinoe & pin_is_input;
      ladder_range_select      <= nxt_range;
      ladder_source_select     <= nxt_source;
      ladder_tap_code          <= nxt_tap;
      ladder_tap_switch        <= nxt_onehot;
      // Low range: 0 + n/24; high range: 8/32 + n/32 of the span
      if (nxt_range) begin
        ladder_step_divisor <= `CRLC_LOW_STEP_DIV;
        ladder_base_taps    <= `CRLC_WORD_ZERO;
      end else begin
        ladder_step_divisor <= `CRLC_HIGH_STEP_DIV;
        ladder_base_taps    <= `CRLC_HIGH_BASE_TAPS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: status shows what actually reaches the ladder and pin

  reg  [DATA_W-1:0] rdata_next;

  always @* begin
    rdata_next = `CRLC_WORD_ZERO;
    if (reg_rd) begin
      if (ctrl_hit) begin
        rdata_next = reference_ladder_control_reg;
      end else if (stat_hit) begin
        rdata_next = {ladder_power_enable, ladder_pin_output_enable,
                      sleep_active, pin_is_input, ladder_tap_code};
      end else begin
        rdata_next = `CRLC_UNMAPPED_DATA;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `CRLC_WORD_ZERO;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule // crlc_ladder_ctrl

// file: rtl/crlc_tap_decode.v
// One-hot tap decoder for the resistor ladder switches
`timescale 1ns/10ps
`include "crlc_consts.vh"

module crlc_tap_decode #(
  parameter TAPS  = `CRLC_TAP_COUNT,
  parameter TAP_W = `CRLC_TAP_W
) (
  input  wire [TAP_W-1:0] tap_code,   // Selected tap code
  input  wire             enable,     // Ladder powered
  output wire [TAPS-1:0]  tap_onehot  // One switch closed per tap
);

  // One comparator per tap; all switches open while powered down
  genvar i;
  generate
    for (i = 0; i < TAPS; i = i + 1) begin : g_tap
      // Index as a sized constant, so only its low bits meet the code
      localparam [31:0] TAP_IDX = i;
      assign tap_onehot[i] = enable & (tap_code == TAP_IDX[TAP_W-1:0]);
    end
  endgenerate

endmodule // crlc_tap_decode

// file: tb/crlc_ladder_ctrl_sva.sv
// Checker for the reference ladder control outputs
`timescale 1ns/10ps
module crlc_ladder_sva (
  input logic        clk, rst, reg_wr, reg_rd, ladder_power_enable,
  input logic        ladder_pin_output_enable, ladder_range_select, ladder_source_select,
  input logic [3:0]  reg_addr, ladder_tap_code,
  input logic [7:0]  reg_wdata, reg_rdata, port_f_direction, ladder_step_divisor,
  input logic [7:0]  ladder_base_taps,
  input logic [15:0] ladder_tap_switch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Control write, the only thing allowed to move the ladder apart from the pin switch, which also follows port_f_direction
  wire wr0 = reg_wr && reg_addr == 4'h0;
  ////////////////////////////////////////////////////////////////////////////////
  power_load_a: assert property (wr0 |=> ladder_power_enable == $past(reg_wdata[7])) // Pwr
    else $error("power enable not loaded");
  range_load_a: assert property (wr0 |=> ladder_range_select == $past(reg_wdata[5]) // Rng
    && {ladder_step_divisor, ladder_base_taps} == ($past(reg_wdata[5]) ? 16'h1800 : 16'h2008))
    else $error("range outputs wrong");
  source_load_a: assert property (wr0 |=> ladder_source_select == $past(reg_wdata[4])) // Src
    else $error("source select not loaded");
  tap_load_a: assert property (wr0 |=> ladder_tap_code == $past(reg_wdata[3:0])) // Tap
    else $error("tap code not loaded");
  tap_onehot_a: assert property (ladder_tap_switch == // Switch
    (ladder_power_enable ? 16'h0001 << ladder_tap_code : 16'h0000)) else $error("tap switch bad");
  pin_load_a: assert property (wr0 |=> ladder_pin_output_enable == // Pin
    ($past(reg_wdata[6]) && $past(port_f_direction[5]))) else $error("pin enable wrong");
  pin_gate_a: assert property (ladder_pin_output_enable |-> $past(port_f_direction[5])) // Dir
    else $error("pin driven without input direction");
  ctrl_hold_a: assert property (!$past(wr0) |-> $stable({ladder_power_enable,
    ladder_range_select, ladder_source_select, ladder_tap_code})) else $error("ladder moved");
  ctrl_read_a: assert property (reg_rd && reg_addr == 4'h0 |=> // Rd
    {reg_rdata[7], reg_rdata[5:0]} == {ladder_power_enable, ladder_range_select,
    ladder_source_select, ladder_tap_code}) else $error("control readback wrong");
endmodule // crlc_ladder_sva

bind crlc_ladder_ctrl crlc_ladder_sva u_sva (.clk, .rst, .reg_wr, .reg_rd, .ladder_power_enable,
  .ladder_pin_output_enable, .ladder_range_select, .ladder_source_select, .reg_addr,
  .ladder_tap_code, .reg_wdata, .reg_rdata, .port_f_direction, .ladder_step_divisor,
  .ladder_base_taps, .ladder_tap_switch);

// file: tb/tb_crlc_ladder_ctrl.sv
// Self-checking bench for the reference ladder control block
`timescale 1ns/10ps
module tb_crlc_ladder_ctrl;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sleep_active = 0, rd_pend = 0;
  logic [3:0]  reg_addr = 4'h0, ladder_tap_code;
  logic [7:0]  reg_wdata = 8'h00, port_f_direction = 8'h00, reg_rdata, d, q[$];
  logic [7:0]  ladder_step_divisor, ladder_base_taps;
  logic [15:0] ladder_tap_switch;
  logic        ladder_power_enable, ladder_pin_output_enable;
  logic        ladder_range_select, ladder_source_select;
  int          err_total = 0, num_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  crlc_ladder_ctrl u_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_f_direction, .sleep_active, .ladder_power_enable, .ladder_pin_output_enable,
    .ladder_range_select, .ladder_source_select, .ladder_tap_code, .ladder_tap_switch,
    .ladder_step_divisor, .ladder_base_taps);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bus cycles; each strobe is set once per edge, so back to back
  // strobes never see a low and a high in one time step; idle drops both
  task wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task outs(input logic [7:0] v);
    chk("power", ladder_power_enable, v[7]); // Power bit
    chk("pin", ladder_pin_output_enable, v[6] & port_f_direction[5]); // Gated pin
    chk("range src", {ladder_range_select, ladder_source_select}, v[5:4]);
    chk("tap", ladder_tap_code, v[3:0]); // Tap code
    chk("span", {ladder_step_divisor, ladder_base_taps}, v[5] ? 16'h1800 : 16'h2008); // Range
    chk("switch", ladder_tap_switch, v[7] ? 16'h0001 << v[3:0] : 16'h0000); // One-hot
  endtask
  // Read data watcher, one cycle behind the strobe; also the hang guard
  always @(posedge clk) begin
    if (rd_pend) chk("rdata", reg_rdata, q.pop_front()); // Readback
    rd_pend <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 2000) begin err_total++; give_verdict(); end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hEAFE));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    outs(8'h00); // Cleared
    rd(4'h0, 8'h00);
    $display("reset test done");
    // All tap codes in both ranges, then random words, back to back with reads
    for (int i = 0; i < 40; i++) begin
      d = 8'($urandom);
      if (i < 32) d[5:0] = {i[4], d[4], i[3:0]};
      port_f_direction <= 8'($urandom);
      wr(4'h0, d);
      rd(4'h0, d);
      idle();
      outs(d);
    end
    $display("write test done");
    // Power down before sleep, then refused writes, status and unmapped reads
    d[7] = 1'b0;
    wr(4'h0, d); // Software powers down first
    wr(4'h1, ~d);
    wr(4'h9, ~d);
    sleep_active <= 1'b1;
    rd(4'h1, {d[7], d[6] & port_f_direction[5], 1'b1, port_f_direction[5], d[3:0]});
    rd(4'hC, 8'h00);
    sleep_active <= 1'b0;
    idle();
    outs(d); // Unchanged
    $display("refuse test done");
    wr(4'h0, 8'hFF);
    reg_wr <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    outs(8'h00); // Cleared again
    rd(4'h0, 8'h00);
    idle();
    @(posedge clk);
    $display("second reset test done");
    give_verdict();
  end
endmodule // tb_crlc_ladder_ctrl
